// *** rthpc_ctrl.v ***
`timescale 1ns/10ps
`default_nettype none
`include "rthpc_map.vh"

// Contract
// - Default heating: on below setpoint minus hysteresis
// - Default heating: off once setpoint reached
// - Default cooling: on above setpoint plus hysteresis
// - Default cooling: off below setpoint
// - Panel heating: on below setpoint, off at plus-hysteresis
// - Panel cooling: on above setpoint, off at minus-hysteresis
// - Separate heating and cooling hysteresis values
// - Default hysteresis below for heat, above cool
// - Reversed hysteresis only for radiant panel terminals
// - Eight setpoints, per mode and season, writable
// - PI: fixed period, on-time proportional to output
// - Setpoint change restarts period with recomputed output
// - Command sent on change or periodically
// - Single, relative or absolute setpoint management
// - Alarm forces command off and flags alarm
module rthpc_ctrl #(
  parameter [31:0] TICK_CYCLES = `RTHPC_TICK_NS / `RTHPC_CLK_PERIOD_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [31:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire alarm_in,
  output reg valve_on,
  output reg alarm_out,
  output reg bus_command_object_valid,
  output reg [7:0] bus_command_object
);
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wmerge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Byte merge into a 16-bit register; the upper half is dropped on purpose
  function [15:0] wmerge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [31:0] full;
    begin
      full = wmerge({16'h0000, old}, data, strb);
      wmerge16 = full[15:0];
    end
  endfunction

  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:8] == 24'h00_0000) && (addr[1:0] == 2'h0) &&
               ((addr[7:5] == `RTHPC_SP_BASE_HI) || (addr[7:0] <= `RTHPC_OFF_STATUS));
    end
  endfunction

  // Clamp a signed sum into the 0..255 output range
  function [7:0] sat8;
    input signed [27:0] v;
    begin
      if (v[27]) begin
        sat8 = 8'h00;
      end else if (v > 28'sh00F_F) begin
        sat8 = 8'hFF;
      end else begin
        sat8 = v[7:0];
      end
    end
  endfunction

  // Sign-extend a 16-bit temperature to the 18-bit compare width
  function signed [17:0] ext18;
    input [15:0] v;
    begin
      ext18 = {{2{v[15]}}, v};
    end
  endfunction

  reg [15:0] ctrl_reg;
  reg [15:0] temp_reg;
  reg [31:0] hyst_reg;
  reg [15:0] pi_reg;
  reg [15:0] per_reg;
  reg [15:0] txp_reg;
  reg [15:0] sp_reg [0:7];
  reg aw_full_reg;
  reg w_full_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg [2:0] alarm_sync_reg;
  reg alarm_pin_reg;
  reg tp_state_reg;
  reg tp_state_next;
  reg [7:0] integ_reg;
  reg [17:0] sp_prev_reg;
  reg sp_chg_reg;
  reg [15:0] tx_cnt_reg;
  reg [7:0] sent_reg;
  reg [31:0] rd_mux;
  reg signed [17:0] sp_eff;
  reg signed [17:0] on_th;
  reg signed [17:0] off_th;
  integer k;

  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid;
  wire aw_full_next = (aw_full_reg | aw_hs) & ~do_write;
  wire w_full_next = (w_full_reg | w_hs) & ~do_write;
  wire rvalid_next = (rvalid & ~rready) | ar_hs;
  wire is_pi = ctrl_reg[`RTHPC_CTRL_PI];
  wire is_cool = ctrl_reg[`RTHPC_CTRL_COOL];
  wire [1:0] opm = ctrl_reg[`RTHPC_CTRL_OPM_HI:`RTHPC_CTRL_OPM_LO];
  wire [1:0] spm = ctrl_reg[`RTHPC_CTRL_SPM_HI:`RTHPC_CTRL_SPM_LO];
  wire radiant = ctrl_reg[`RTHPC_CTRL_TERM_HI:`RTHPC_CTRL_TERM_LO] == `RTHPC_TERM_RADIANT;
  wire rev = ctrl_reg[`RTHPC_CTRL_REV] & radiant;
  wire alarm = ctrl_reg[`RTHPC_CTRL_ALARM] | alarm_pin_reg;
  wire signed [17:0] t18 = ext18(temp_reg);
  wire signed [17:0] hh = ext18(hyst_reg[15:0]);
  wire signed [17:0] hc = ext18(hyst_reg[31:16]);
  wire signed [17:0] err = is_cool ? (t18 - sp_eff) : (sp_eff - t18);
  wire signed [26:0] p_prod = err * $signed({1'b0, pi_reg[7:0]});
  wire signed [26:0] i_prod = err * $signed({1'b0, pi_reg[15:8]});
  wire signed [27:0] p_term = {p_prod[26], p_prod >>> 6};
  wire signed [27:0] i_term = {i_prod[26], i_prod >>> 8};
  wire signed [27:0] integ_ext = {{20{1'b0}}, integ_reg};
  wire [7:0] cv = sat8(p_term + integ_ext);
  wire [7:0] pi_duty = alarm ? `RTHPC_CMD_OFF : cv;
  wire pwm_on;
  wire pwm_start;
  wire valve_next = alarm ? 1'b0 : (is_pi ? pwm_on : tp_state_next);
  wire [7:0] cmd_next = alarm ? `RTHPC_CMD_OFF : (is_pi ? pi_duty : (tp_state_next ? `RTHPC_CMD_FULL : `RTHPC_CMD_OFF));
  wire tx_due = (txp_reg != 16'h0000) && tick_reg && (tx_cnt_reg >= txp_reg - 16'h0001);

  // Effective setpoint from management mode and operating mode
  always @* begin
    sp_eff = ext18(sp_reg[{is_cool, opm}]);
    case (spm)
      `RTHPC_SPM_SINGLE: begin
        sp_eff = ext18(sp_reg[{is_cool, (opm == `RTHPC_OPM_PROT) ? `RTHPC_OPM_PROT : `RTHPC_OPM_COMFORT}]);
      end
      `RTHPC_SPM_REL: begin
        if (opm == `RTHPC_OPM_STBY || opm == `RTHPC_OPM_ECO) begin
          sp_eff = is_cool ? (ext18(sp_reg[{1'b1, `RTHPC_OPM_COMFORT}]) + ext18(sp_reg[{1'b1, opm}]))
                           : (ext18(sp_reg[{1'b0, `RTHPC_OPM_COMFORT}]) - ext18(sp_reg[{1'b0, opm}]));
        end
      end
      `RTHPC_SPM_ABS: begin
        sp_eff = ext18(sp_reg[{is_cool, opm}]);
      end
      default: begin
        sp_eff = ext18(sp_reg[{is_cool, `RTHPC_OPM_COMFORT}]);
      end
    endcase
  end

  // Two-point thresholds; default places hysteresis below heat, above cool
  always @* begin
    if (!is_cool) begin
      on_th = rev ? sp_eff : (sp_eff - hh);
      off_th = rev ? (sp_eff + hh) : sp_eff;
    end else begin
      on_th = rev ? sp_eff : (sp_eff + hc);
      off_th = rev ? (sp_eff - hc) : sp_eff;
    end
    tp_state_next = tp_state_reg;
    if (alarm) begin
      tp_state_next = 1'b0;
    end else if (!is_cool) begin
      if (t18 < on_th) begin
        tp_state_next = 1'b1;
      end else if (t18 >= off_th) begin
        tp_state_next = 1'b0;
      end
    end else begin
      if (t18 > on_th) begin
        tp_state_next = 1'b1;
      end else if (rev ? (t18 <= off_th) : (t18 < off_th)) begin
        tp_state_next = 1'b0;
      end
    end
  end

  // Read data mux; reserved bits read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (araddr[7:5] == `RTHPC_SP_BASE_HI) begin
      rd_mux = {16'h0000, sp_reg[araddr[4:2]]};
    end else begin
      case (araddr[7:0])
        `RTHPC_OFF_CTRL: rd_mux = {16'h0000, ctrl_reg};
        `RTHPC_OFF_TEMP: rd_mux = {16'h0000, temp_reg};
        `RTHPC_OFF_HYST: rd_mux = hyst_reg;
        `RTHPC_OFF_PI: rd_mux = {16'h0000, pi_reg};
        `RTHPC_OFF_PERIOD: rd_mux = {16'h0000, per_reg};
        `RTHPC_OFF_TXPER: rd_mux = {16'h0000, txp_reg};
        `RTHPC_OFF_STATUS: rd_mux = {sp_eff[15:0], cv, 5'h00, tp_state_reg, alarm_out, valve_on};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // AXI4-Lite slave; address and data are taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RTHPC_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RTHPC_RESP_OKAY;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready <= ~aw_full_next;
      wready <= ~w_full_next;
      if (aw_hs) begin
        awaddr_reg <= awaddr;
      end
      if (w_hs) begin
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= mapped(awaddr_reg) ? `RTHPC_RESP_OKAY : `RTHPC_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      rvalid <= rvalid_next;
      arready <= ~rvalid_next;
      if (ar_hs) begin
        rdata <= mapped(araddr) ? rd_mux : 32'h0000_0000;
        rresp <= mapped(araddr) ? `RTHPC_RESP_OKAY : `RTHPC_RESP_SLVERR;
      end
    end
  end

  // Register file writes; setpoints stay writable after configuration
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `RTHPC_RST_CTRL;
      temp_reg <= `RTHPC_RST_TEMP;
      hyst_reg <= `RTHPC_RST_HYST;
      pi_reg <= `RTHPC_RST_PI;
      per_reg <= `RTHPC_RST_PERIOD;
      txp_reg <= `RTHPC_RST_TXPER;
      sp_reg[0] <= `RTHPC_RST_SP_H0;
      sp_reg[1] <= `RTHPC_RST_SP_H1;
      sp_reg[2] <= `RTHPC_RST_SP_H2;
      sp_reg[3] <= `RTHPC_RST_SP_H3;
      sp_reg[4] <= `RTHPC_RST_SP_C0;
      sp_reg[5] <= `RTHPC_RST_SP_C1;
      sp_reg[6] <= `RTHPC_RST_SP_C2;
      sp_reg[7] <= `RTHPC_RST_SP_C3;
    end else if (do_write && mapped(awaddr_reg)) begin
      if (awaddr_reg[7:5] == `RTHPC_SP_BASE_HI) begin
        sp_reg[awaddr_reg[4:2]] <= wmerge16(sp_reg[awaddr_reg[4:2]], wdata_reg, wstrb_reg);
      end else begin
        case (awaddr_reg[7:0])
          `RTHPC_OFF_CTRL: ctrl_reg <= wmerge16(ctrl_reg, wdata_reg, wstrb_reg);
          `RTHPC_OFF_TEMP: temp_reg <= wmerge16(temp_reg, wdata_reg, wstrb_reg);
          `RTHPC_OFF_HYST: hyst_reg <= wmerge(hyst_reg, wdata_reg, wstrb_reg);
          `RTHPC_OFF_PI: pi_reg <= wmerge16(pi_reg, wdata_reg, wstrb_reg);
          `RTHPC_OFF_PERIOD: per_reg <= wmerge16(per_reg, wdata_reg, wstrb_reg);
          `RTHPC_OFF_TXPER: txp_reg <= wmerge16(txp_reg, wdata_reg, wstrb_reg);
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // Base tick, alarm pin filter and control state
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      alarm_sync_reg <= 3'h0;
      alarm_pin_reg <= 1'b0;
      tp_state_reg <= 1'b0;
      integ_reg <= 8'h00;
      sp_prev_reg <= 18'h0_0000;
      sp_chg_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg >= TICK_CYCLES - 32'h0000_0001);
      tick_cnt_reg <= (tick_cnt_reg >= TICK_CYCLES - 32'h0000_0001) ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      alarm_sync_reg <= {alarm_sync_reg[1:0], alarm_in};
      // Only a level both late stages agree on counts
      if (alarm_sync_reg[2] == alarm_sync_reg[1]) begin
        alarm_pin_reg <= alarm_sync_reg[2];
      end
      tp_state_reg <= tp_state_next;
      sp_prev_reg <= sp_eff;
      sp_chg_reg <= (sp_eff != sp_prev_reg);
      // Integral clamps to 0..255 so it cannot wind up while saturated
      if (alarm || !is_pi) begin
        integ_reg <= 8'h00;
      end else if (pwm_start) begin
        integ_reg <= sat8(integ_ext + i_term);
      end
    end
  end

  rthpc_pwm u_pwm (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_reg),
    .restart(sp_chg_reg),
    .period_ticks(per_reg),
    .duty(pi_duty),
    .pwm_on(pwm_on),
    .start(pwm_start)
  );

  // Outputs and command object: sent when it changes or on the repeat timer
  always @(posedge aclk) begin
    if (!aresetn) begin
      valve_on <= 1'b0;
      alarm_out <= 1'b0;
      bus_command_object_valid <= 1'b0;
      bus_command_object <= `RTHPC_CMD_OFF;
      sent_reg <= `RTHPC_CMD_OFF;
      tx_cnt_reg <= 16'h0000;
    end else begin
      valve_on <= valve_next;
      alarm_out <= alarm;
      if (tx_due || !tick_reg || txp_reg == 16'h0000) begin
        tx_cnt_reg <= (tx_due || txp_reg == 16'h0000) ? 16'h0000 : tx_cnt_reg;
      end else begin
        tx_cnt_reg <= tx_cnt_reg + 16'h0001;
      end
      bus_command_object_valid <= (cmd_next != sent_reg) | tx_due;
      bus_command_object <= cmd_next;
      sent_reg <= cmd_next;
    end
  end
endmodule

`default_nettype wire

// *** rthpc_ctrl_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

// Port checks: bus answers, telegram pulses, alarm forcing
module rthpc_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic alarm_out,
  input wire logic valve_on,
  input wire logic bus_command_object_valid,
  input wire logic [7:0] bus_command_object
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Handshakes that launch an answer
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  property p_wr_answer;
    s_wr_taken |-> !bvalid ##2 bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_done;
    bvalid && bready |=> !bvalid;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write answer stuck");
  property p_rd_answer;
    s_rd_taken |=> rvalid && !arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_done;
    rvalid && rready |=> !rvalid;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read answer stuck");
  property p_resp;
    bvalid |-> bresp == 2'h0 || bresp == 2'h2;
  endproperty
  a_resp: assert property (p_resp) else $error("bad write response");
  // Two cycles of margin let the forcing path settle
  property p_alarm;
    alarm_out && $past(alarm_out, 2) |-> !valve_on && bus_command_object == 8'h00;
  endproperty
  a_alarm: assert property (p_alarm) else $error("command not closed in alarm");
  property p_send;
    $changed(bus_command_object) |-> bus_command_object_valid;
  endproperty
  a_send: assert property (p_send) else $error("command changed unsent");
  property p_pulse;
    bus_command_object_valid |=> !bus_command_object_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("send pulse too long");
endmodule

bind rthpc_ctrl rthpc_ctrl_chk u_rthpc_ctrl_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .alarm_out, .valve_on,
  .bus_command_object_valid, .bus_command_object);

`default_nettype wire

// *** rthpc_map.vh ***
`ifndef RTHPC_MAP_VH
`define RTHPC_MAP_VH

// Register byte offsets
`define RTHPC_OFF_CTRL 8'h00
`define RTHPC_OFF_TEMP 8'h04
`define RTHPC_OFF_HYST 8'h08
`define RTHPC_OFF_PI 8'h0C
`define RTHPC_OFF_PERIOD 8'h10
`define RTHPC_OFF_TXPER 8'h14
`define RTHPC_OFF_STATUS 8'h18
`define RTHPC_SP_BASE_HI 3'h1

// Control register fields
`define RTHPC_CTRL_PI 0
`define RTHPC_CTRL_COOL 1
`define RTHPC_CTRL_REV 2
`define RTHPC_CTRL_ALARM 3
`define RTHPC_CTRL_OPM_LO 4
`define RTHPC_CTRL_OPM_HI 5
`define RTHPC_CTRL_SPM_LO 6
`define RTHPC_CTRL_SPM_HI 7
`define RTHPC_CTRL_TERM_LO 8
`define RTHPC_CTRL_TERM_HI 9

// Setpoint management modes, operating modes, terminal types
`define RTHPC_SPM_SINGLE 2'h0
`define RTHPC_SPM_REL 2'h1
`define RTHPC_SPM_ABS 2'h2
`define RTHPC_OPM_COMFORT 2'h0
`define RTHPC_OPM_STBY 2'h1
`define RTHPC_OPM_ECO 2'h2
`define RTHPC_OPM_PROT 2'h3
`define RTHPC_TERM_RADIANT 2'h3

// Reset values
`define RTHPC_RST_CTRL 16'h0000
`define RTHPC_RST_TEMP 16'h07D0
`define RTHPC_RST_HYST 32'h0032_0032
`define RTHPC_RST_PI 16'h0410
`define RTHPC_RST_PERIOD 16'h0384
`define RTHPC_RST_TXPER 16'h0000
`define RTHPC_RST_SP_H0 16'h07D0
`define RTHPC_RST_SP_H1 16'h00C8
`define RTHPC_RST_SP_H2 16'h012C
`define RTHPC_RST_SP_H3 16'h0320
`define RTHPC_RST_SP_C0 16'h0A28
`define RTHPC_RST_SP_C1 16'h00C8
`define RTHPC_RST_SP_C2 16'h012C
`define RTHPC_RST_SP_C3 16'h0E10

// Bus answers and command values
`define RTHPC_RESP_OKAY 2'h0
`define RTHPC_RESP_SLVERR 2'h2
`define RTHPC_CMD_FULL 8'hFF
`define RTHPC_CMD_OFF 8'h00

// Timing: clock period and base tick, both in ns
`define RTHPC_CLK_PERIOD_NS 25
`define RTHPC_TICK_NS 1000000000

`endif

// *** rthpc_pwm.v ***
`timescale 1ns/10ps
`default_nettype none

// Period modulator: one cycle of period_ticks ticks, on for duty/255 of it
module rthpc_pwm (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire restart,
  input wire [15:0] period_ticks,
  input wire [7:0] duty,
  output reg pwm_on,
  output reg start
);
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg [7:0] duty_reg;
  reg [7:0] duty_next;
  reg start_now;

  // A restart aborts the running cycle and latches a fresh duty at once
  always @* begin
    start_now = restart | (tick & (cnt_reg >= period_ticks - 16'h0001));
    cnt_next = cnt_reg;
    duty_next = duty_reg;
    if (start_now) begin
      cnt_next = 16'h0000;
      duty_next = duty;
    end else if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
      duty_reg <= 8'h00;
      pwm_on <= 1'b0;
      start <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      duty_reg <= duty_next;
      start <= start_now;
      // On-time proportional to duty; cross-multiply avoids a divider
      pwm_on <= ({8'h00, cnt_next} * 24'h00_00FF) < ({16'h0000, duty_next} * {8'h00, period_ticks});
    end
  end
endmodule

`default_nettype wire

// *** rthpc_valve_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Valve actuator on the far side: it only moves on a command telegram
module rthpc_valve_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd,
  output logic [7:0] last_cmd
);
  // A value held between telegrams is not seen, so a silent change fails
  always @(posedge aclk) begin
    if (!aresetn) begin
      last_cmd <= 8'h00;
    end else if (cmd_valid) begin
      last_cmd <= cmd;
    end
  end
endmodule

`default_nettype wire

// *** tb.sv ***
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdv;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, alarm_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, valve_on, alarm_out, bus_command_object_valid;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] bus_command_object, last_cmd;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h3C};
  logic [31:0] rv [8] = '{32'h0000_0000, 32'h0000_07D0, 32'h0032_0032, 32'h0000_0410,
    32'h0000_0384, 32'h0000_0000, 32'h0000_07D0, 32'h0000_0E10};
  logic [15:0] sp_exp [3] = '{16'h07D0, 16'h01D0, 16'h0600};
  int n_errors = 0, checks = 0, on_cnt;

  // Short tick so a modulation period lasts tens of cycles
  rthpc_ctrl #(.TICK_CYCLES(32'd4)) u_rthpc_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .alarm_in, .valve_on, .alarm_out, .bus_command_object_valid, .bus_command_object);
  rthpc_valve_model u_rthpc_valve_model (.aclk, .aresetn, .cmd_valid(bus_command_object_valid),
    .cmd(bus_command_object), .last_cmd);

  always #12.5 aclk = ~aclk;

  // Setpoints and settings only reach the block as bus writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= {24'h0000_00, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= {24'h0000_00, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
    resp = rresp;
  endtask

  // Valve and last telegram after the command has had time to land
  task automatic out(input logic v);
    repeat (3) @(posedge aclk);
    `CHK(valve_on, v)
    `CHK(last_cmd, v ? 8'hFF : 8'h00)
  endtask

  task automatic tp(input logic [15:0] t, input logic v);
    wr(8'h04, {16'h0000, t});
    out(v);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(rdv, rv[i])
    end
    rd(8'h40);
    `CHK({resp, rdv}, {2'h2, 32'h0000_0000})
    wr(8'h02, 32'h0000_0000);
    `CHK(resp, 2'h2)
    $display("registers done");
    tp(16'h079E, 1'b0);
    tp(16'h079D, 1'b1);
    tp(16'h07CF, 1'b1);
    tp(16'h07D0, 1'b0);
    $display("default heating done");
    wr(8'h08, 32'h0064_0032);
    wr(8'h00, 32'h0000_0002);
    tp(16'h0A8C, 1'b0);
    tp(16'h0A8D, 1'b1);
    tp(16'h0A28, 1'b1);
    tp(16'h0A27, 1'b0);
    $display("default cooling done");
    wr(8'h00, 32'h0000_0004);
    tp(16'h07CF, 1'b0);
    wr(8'h00, 32'h0000_0304);
    tp(16'h07CE, 1'b1);
    tp(16'h0801, 1'b1);
    tp(16'h0802, 1'b0);
    wr(8'h00, 32'h0000_0306);
    tp(16'h0A29, 1'b1);
    tp(16'h09C5, 1'b1);
    tp(16'h09C4, 1'b0);
    $display("radiant panels done");
    wr(8'h00, 32'h0000_0304);
    tp(16'h07CE, 1'b1);
    wr(8'h00, 32'h0000_030C);
    out(1'b0);
    `CHK(alarm_out, 1'b1)
    wr(8'h00, 32'h0000_0304);
    out(1'b1);
    alarm_in <= 1'b1;
    // Pin passes the synchroniser and agreement filter before forcing
    repeat (4) @(posedge aclk);
    out(1'b0);
    repeat (3) @(posedge aclk);
    `CHK(alarm_out, 1'b1)
    alarm_in <= 1'b0;
    $display("alarm done");
    // Economy setpoint seen through each management mode
    wr(8'h28, 32'h0000_0600);
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 32'h20 | (m << 6));
      rd(8'h18);
      `CHK(rdv[31:16], sp_exp[m])
    end
    $display("setpoint modes done");
    wr(8'h10, 32'h0000_0008);
    // Cold room first, so the setpoint jump into PI mode latches full duty
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    out(1'b1);
    repeat (80) @(posedge aclk);
    on_cnt = 0;
    repeat (64) begin
      @(posedge aclk);
      on_cnt += valve_on;
    end
    `CHK(on_cnt, 64)
    wr(8'h04, 32'h0000_0FA0);
    wr(8'h20, 32'h0000_07D1);
    out(1'b0);
    $display("modulation done");
    results();
  end
endmodule

`default_nettype wire
